/* File: design/trr_pkg.sv */
package trr_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int                     NUM_CH        = 3;
  localparam logic [7:0]             ADDR_FRACTION = 8'h77;
  localparam logic [7:0]             ADDR_CONFIG5  = 8'h7C;
  // Channel order: remote one, local, remote two.
  localparam logic [2:0][7:0]        ADDR_VALUE    = {8'h27, 8'h26, 8'h25};
  localparam logic [2:0][7:0]        ADDR_LOW      = {8'h52, 8'h50, 8'h4E};
  localparam logic [2:0][7:0]        ADDR_HIGH     = {8'h53, 8'h51, 8'h4F};
  localparam logic [2:0][7:0]        ADDR_OFFSET   = {8'h72, 8'h71, 8'h70};

  // ---------------------------------------------------------------
  // Reset values and fields
  // ---------------------------------------------------------------
  localparam logic [7:0]             RST_LOW       = 8'h01;
  localparam logic [7:0]             RST_HIGH      = 8'h7F;
  localparam logic [7:0]             RST_OFFSET    = 8'h00;
  localparam logic [9:0]             RST_VALUE     = 10'h000;
  localparam logic                   RST_COMPAT    = 1'b0;
  localparam int                     CFG5_COMPAT   = 1;
  localparam int                     FRAC_LSB      = 2;
  localparam int                     FRAC_STRIDE   = 2;

  // ---------------------------------------------------------------
  // Encodings, in quarter degrees; COMPAT_FLOOR in whole degrees
  // ---------------------------------------------------------------
  localparam logic signed [11:0]     BIAS_Q        = 12'sh100;
  localparam logic signed [11:0]     MIN_NORMAL_Q  = -12'sh200;
  localparam logic signed [11:0]     MAX_NORMAL_Q  = 12'sh1FF;
  localparam logic signed [11:0]     MIN_COMPAT_Q  = -12'sh100;
  localparam logic signed [11:0]     MAX_EXT_Q     = 12'sh2FF;
  localparam logic [9:0]             FAULT_TWOS    = 10'h200;
  localparam logic [9:0]             FAULT_EXT     = 10'h000;
  localparam logic [7:0]             COMPAT_FLOOR  = 8'hC1;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic [1:0] chan;
    logic       fault;
    logic [9:0] code;
  } trr_meas_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } trr_bus_req_t;

endpackage : trr_pkg

/* File: design/trr_result_regs.sv */
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Add signed channel offset to every non-fault result.
// - Offset LSB weighs half a degree.
// - Offsets at 0x70-0x72, reset to zero.
// - Value MSBs readable at 0x25-0x27.
// - Fraction register 0x77 packs two-bit remainders.
// - Normal range: ten-bit two's complement quarters.
// - Extended range: offset-64 binary code.
// - Compat bit stores two's complement, -64..127.
// - Compat mode computes biased, then clamps.
// - Compat limits below -63 clamp to -63.
// - Fault code depends on encoding mode.
// - Limit registers with 0x01/0x7F resets.
// - Limit violation sets status and alert.
// - Byte value reads have no ordering.
// - Fraction read freezes values until read.
// - High is greater-than, low is less-or-equal.
// - Status follows each channel's last comparison.
module trr_result_regs (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  // Register port
  input  wire trr_pkg::trr_bus_req_t bus_req,
  output logic [7:0]                 rd_data,
  output logic                       rd_valid,
  // Measurement results, biased extended code
  input  wire trr_pkg::trr_meas_t    meas,
  // Range select pin
  input  wire logic                  range_ext_pin,
  // Status
  output logic [2:0]                 limit_status,
  output logic                       temp_alert,
  output logic                       frozen
);

  localparam int N = trr_pkg::NUM_CH;

  // ---------------------------------------------------------------
  // Encoding helpers
  // ---------------------------------------------------------------
  function automatic logic [9:0] encode(input logic signed [11:0] q,
                                        input logic compat,
                                        input logic ext);
    logic signed [11:0] lo;
    logic signed [11:0] hi;
    logic signed [11:0] c;
    lo = compat ? trr_pkg::MIN_COMPAT_Q
       : (ext ? trr_pkg::MIN_COMPAT_Q : trr_pkg::MIN_NORMAL_Q);
    hi = (!compat && ext) ? trr_pkg::MAX_EXT_Q : trr_pkg::MAX_NORMAL_Q;
    c  = (q < lo) ? lo : ((q > hi) ? hi : q);
    if (!compat && ext) begin
      encode = 10'(c + trr_pkg::BIAS_Q);
    end else begin
      encode = c[9:0];
    end
  endfunction : encode

  function automatic logic signed [11:0] decode(input logic [9:0] code,
                                                input logic compat,
                                                input logic ext);
    if (!compat && ext) begin
      decode = $signed({2'b00, code}) - trr_pkg::BIAS_Q;
    end else begin
      decode = {{2{code[9]}}, code};
    end
  endfunction : decode

  // ---------------------------------------------------------------
  // Range pin synchroniser and compatibility bit
  // ---------------------------------------------------------------
  logic range_meta;
  logic range_ext;
  logic cfg_compat;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      range_meta <= 1'b0;
      range_ext  <= 1'b0;
    end else begin
      range_meta <= range_ext_pin;
      range_ext  <= range_meta;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cfg_compat <= trr_pkg::RST_COMPAT;
    end else if (bus_req.wr && bus_req.addr == trr_pkg::ADDR_CONFIG5) begin
      cfg_compat <= bus_req.wdata[trr_pkg::CFG5_COMPAT];
    end
  end

  // ---------------------------------------------------------------
  // Per-channel registers
  // ---------------------------------------------------------------
  logic [7:0] low_limit  [N];
  logic [7:0] high_limit [N];
  logic [7:0] offset_reg [N];
  logic [9:0] live_value [N];
  logic [9:0] shown      [N];
  logic [N-1:0] value_hit;
  logic       freeze_req;
  logic [7:0] wr_limit;

  assign freeze_req = bus_req.rd && bus_req.addr == trr_pkg::ADDR_FRACTION;

  // Writes below the floor are pulled up only while compat is set.
  assign wr_limit = (cfg_compat &&
                     $signed(bus_req.wdata) <
                     $signed(trr_pkg::COMPAT_FLOOR))
                  ? trr_pkg::COMPAT_FLOOR : bus_req.wdata;

  logic signed [11:0] adj_q;
  logic [9:0]         next_code;

  // The raw code is always biased extended; one adder serves all modes.
  assign adj_q = ($signed({2'b00, meas.code}) - trr_pkg::BIAS_Q)
               + $signed({{3{offset_reg[meas.chan][7]}},
                          offset_reg[meas.chan], 1'b0});

  always_comb begin
    if (meas.fault) begin
      next_code = (!cfg_compat && range_ext)
                ? trr_pkg::FAULT_EXT : trr_pkg::FAULT_TWOS;
    end else begin
      next_code = encode(adj_q, cfg_compat,
                         range_ext);
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_ch
      assign value_hit[g] = bus_req.rd &&
                            bus_req.addr == trr_pkg::ADDR_VALUE[g];

      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          low_limit[g]  <= trr_pkg::RST_LOW;
          high_limit[g] <= trr_pkg::RST_HIGH;
          offset_reg[g] <= trr_pkg::RST_OFFSET;
        end else if (bus_req.wr) begin
          if (bus_req.addr == trr_pkg::ADDR_LOW[g]) begin
            low_limit[g] <= wr_limit;
          end
          if (bus_req.addr == trr_pkg::ADDR_HIGH[g]) begin
            high_limit[g] <= wr_limit;
          end
          if (bus_req.addr == trr_pkg::ADDR_OFFSET[g]) begin
            offset_reg[g] <= bus_req.wdata;
          end
        end
      end

      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          live_value[g] <= trr_pkg::RST_VALUE;
        end else if (meas.valid && meas.chan == 2'(g)) begin
          live_value[g] <= next_code;
        end
      end

      // Results keep landing in live_value while frozen, so nothing is
      // lost; only the copy software sees is held.
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          shown[g] <= trr_pkg::RST_VALUE;
        end else if (!frozen && !freeze_req) begin
          shown[g] <= live_value[g];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Freeze control
  // ---------------------------------------------------------------
  logic [N-1:0] pending;
  logic [N-1:0] next_pending;

  assign next_pending = pending & ~value_hit;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      frozen  <= 1'b0;
      pending <= '0;
    end else if (freeze_req) begin
      frozen  <= 1'b1;
      pending <= '1;
    end else if (frozen) begin
      pending <= next_pending;
      frozen  <= |next_pending;
    end
  end

  // ---------------------------------------------------------------
  // Limit comparison and status
  // ---------------------------------------------------------------
  logic signed [11:0] res_q;
  logic signed [11:0] hi_q;
  logic signed [11:0] lo_q;
  logic               out_of_limit;

  always_comb begin
    res_q = decode(next_code, cfg_compat, range_ext);
    hi_q  = decode({high_limit[meas.chan], 2'b00}, cfg_compat, range_ext);
    lo_q  = decode({low_limit[meas.chan], 2'b00}, cfg_compat, range_ext);
    out_of_limit = (res_q > hi_q) || (res_q <= lo_q);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      limit_status <= '0;
    end else if (meas.valid && meas.chan < 2'(N)) begin
      limit_status[meas.chan] <= out_of_limit;
    end
  end

  // The alert trails the status by one clock.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      temp_alert <= 1'b0;
    end else begin
      temp_alert <= |limit_status;
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  logic [7:0] next_rd_data;

  always_comb begin
    next_rd_data = 8'h00;
    if (bus_req.addr == trr_pkg::ADDR_FRACTION) begin
      for (int i = 0; i < N; i++) begin
        next_rd_data[trr_pkg::FRAC_LSB + trr_pkg::FRAC_STRIDE*i +: 2] =
          shown[i][1:0];
      end
    end
    if (bus_req.addr == trr_pkg::ADDR_CONFIG5) begin
      next_rd_data[trr_pkg::CFG5_COMPAT] = cfg_compat;
    end
    for (int i = 0; i < N; i++) begin
      if (bus_req.addr == trr_pkg::ADDR_VALUE[i]) begin
        next_rd_data = shown[i][9:2];
      end
      if (bus_req.addr == trr_pkg::ADDR_LOW[i]) begin
        next_rd_data = low_limit[i];
      end
      if (bus_req.addr == trr_pkg::ADDR_HIGH[i]) begin
        next_rd_data = high_limit[i];
      end
      if (bus_req.addr == trr_pkg::ADDR_OFFSET[i]) begin
        next_rd_data = offset_reg[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= bus_req.rd;
      if (bus_req.rd) begin
        rd_data <= next_rd_data;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_fault_twos_code: assert property (
    meas.valid && meas.fault && meas.chan == 2'd0 &&
    (cfg_compat || !range_ext) |=> live_value[0] == trr_pkg::FAULT_TWOS)
    else $error("Fault code wrong in two's complement mode.");

  a_fault_ext_code: assert property (
    meas.valid && meas.fault && meas.chan == 2'd1 &&
    !cfg_compat && range_ext |=> live_value[1] == trr_pkg::FAULT_EXT)
    else $error("Fault code wrong in extended mode.");

  a_ext_passthru: assert property (
    meas.valid && !meas.fault && meas.chan == 2'd2 &&
    !cfg_compat && range_ext && offset_reg[2] == 8'h00
    |=> live_value[2] == $past(meas.code))
    else $error("Extended code altered with zero offset.");

  a_offset_add: assert property (
    meas.valid && !meas.fault && meas.chan == 2'd0 && !cfg_compat &&
    !range_ext && offset_reg[0] == 8'h02 && meas.code == 10'h100
    |=> live_value[0] == 10'h004)
    else $error("Offset not added at half-degree weight.");

  a_compat_floor: assert property (
    cfg_compat && bus_req.wr && bus_req.addr == 8'h4E &&
    bus_req.wdata == 8'h80 |=> low_limit[0] == 8'hC1)
    else $error("Compat limit not clamped to -63.");

  a_compat_range: assert property (
    meas.valid && !meas.fault && cfg_compat && meas.chan == 2'd1 &&
    meas.code == 10'h000 && offset_reg[1][7] |=> live_value[1] == 10'h300)
    else $error("Compat result below -64 not clamped.");

  a_freeze_start: assert property (
    freeze_req |=> frozen && $stable(shown[0]) ##1 $stable(shown[0]))
    else $error("Fraction read did not freeze values.");

  a_freeze_hold: assert property (
    frozen |=> $stable(shown[2]))
    else $error("Shown value changed while frozen.");

  a_freeze_release: assert property (
    freeze_req ##1 value_hit[0] ##1 value_hit[1] ##1 value_hit[2] |=> !frozen)
    else $error("Freeze not released after all value reads.");

  a_value_read: assert property (
    bus_req.rd && bus_req.addr == 8'h26 |=> rd_valid &&
    rd_data == $past(shown[1][9:2]))
    else $error("Local value read returned wrong byte.");

  a_status_alert: assert property (
    meas.valid && meas.chan == 2'd0 && out_of_limit
    |=> limit_status[0] ##1 (temp_alert || !limit_status[0]))
    else $error("Limit violation not flagged.");

  a_low_equal: assert property (
    meas.valid && meas.chan == 2'd2 && res_q == lo_q |=> limit_status[2])
    else $error("Low limit equality not flagged.");

  c_freeze_cycle: cover property (freeze_req ##[1:20] !frozen);
  c_compat_fault: cover property (meas.valid && meas.fault && cfg_compat);
  c_high_trip: cover property (meas.valid && res_q > hi_q);

endmodule : trr_result_regs

`default_nettype wire

/* File: verification/trr_host.sv */
`timescale 1ns/1ps
`default_nettype none

// Host on the register side; it changes its request only at falling edges.
module trr_host (
  // Clock
  input  wire logic                  sys_clk,
  // Register port
  output var trr_pkg::trr_bus_req_t  bus_req
);

  initial bus_req = '0;

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    bus_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(negedge sys_clk);
    bus_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: ~a};
  endtask : rd

  task automatic idle();
    @(negedge sys_clk);
    bus_req <= '{rd: 1'b0, wr: 1'b0, addr: 8'hFF, wdata: 8'hA5};
  endtask : idle

  // Fractions go first so that no byte moves under its two low bits.
  task automatic rd_wide();
    rd(trr_pkg::ADDR_FRACTION);
    for (int i = 0; i < trr_pkg::NUM_CH; i++) begin
      rd(trr_pkg::ADDR_VALUE[i]);
    end
  endtask : rd_wide

endmodule : trr_host

`default_nettype wire

/* File: verification/trr_result_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module trr_result_regs_tb;

  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  logic                  sys_clk       = 1'b0;
  logic                  sys_rst       = 1'b1;
  trr_pkg::trr_bus_req_t bus_req;
  logic [7:0]            rd_data;
  logic                  rd_valid;
  trr_pkg::trr_meas_t    meas          = '0;
  logic                  range_ext_pin = 1'b0;
  logic [2:0]            limit_status;
  logic                  temp_alert;
  logic                  frozen;
  int                    n_mismatch    = 0;
  int                    checks        = 0;
  int                    cycles        = 0;
  logic [15:0]           exp_q[$];
  logic [9:0]            val[3]        = '{default: 10'h000};
  logic [7:0]            offs[3]       = '{default: 8'h00};
  logic [2:0]            stat          = 3'h0;
  logic                  ext           = 1'b0;
  logic                  cmp           = 1'b0;
  localparam logic [15:0] RST_TBL [15] = '{16'h4E01, 16'h4F7F, 16'h5001,
    16'h517F, 16'h5201, 16'h537F, 16'h7000, 16'h7100, 16'h7200, 16'h7700,
    16'h2500, 16'h2600, 16'h2700, 16'h7C00, 16'h3000};

  always #10 sys_clk = ~sys_clk;

  trr_result_regs uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .bus_req(bus_req), .rd_data(rd_data), .rd_valid(rd_valid), .meas(meas),
    .range_ext_pin(range_ext_pin), .limit_status(limit_status),
    .temp_alert(temp_alert), .frozen(frozen));

  trr_host host (.sys_clk(sys_clk), .bus_req(bus_req));

  // --------------------------------------------------------------
  // Expected values
  // --------------------------------------------------------------
  function automatic int clip(input int v, input int lo, input int hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clip

  function automatic logic [9:0] enc(input logic [9:0] raw,
                                     input logic [7:0] off, input logic flt);
    int q;
    q = int'(raw) + 2 * int'($signed(off));
    if (flt) return (ext && !cmp) ? trr_pkg::FAULT_EXT : trr_pkg::FAULT_TWOS;
    if (cmp) q = clip(q - 256, -256, 511);
    else if (ext) q = clip(q, 0, 1023);
    else q = clip(q - 256, -512, 511);
    return q[9:0];
  endfunction : enc

  function automatic int sv(input logic [9:0] v);
    return (ext && !cmp) ? int'(v) : int'($signed(v));
  endfunction : sv

  // --------------------------------------------------------------
  // Checking
  // --------------------------------------------------------------
  task automatic chk(input string what, input logic [9:0] e,
                     input logic [9:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic rx(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({a, e});
    host.rd(a);
  endtask : rx

  task automatic read_wide();
    exp_q.push_back({trr_pkg::ADDR_FRACTION, val[2][1:0], val[1][1:0],
                     val[0][1:0], 2'b00});
    for (int k = 0; k < 3; k++) exp_q.push_back({trr_pkg::ADDR_VALUE[k], val[k][9:2]});
    host.rd_wide();
    host.idle();
  endtask : read_wide

  task automatic measure(input int c, input logic [9:0] raw,
                         input logic flt);
    @(negedge sys_clk);
    meas <= '{valid: 1'b1, chan: c[1:0], fault: flt, code: raw};
    @(negedge sys_clk);
    meas.valid <= 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask : measure

  // Answers are matched in request order, so a lost or extra rd_valid shows.
  always @(negedge sys_clk) begin : monitor
    logic [15:0] e;
    if (rd_valid === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hFFFF;
      chk($sformatf("register %h", e[15:8]), {2'b00, e[7:0]},
          {2'b00, rd_data});
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  // --------------------------------------------------------------
  // Stimulus
  // --------------------------------------------------------------
  initial begin
    logic [7:0] lo, hi, w;
    logic [9:0] raw;
    logic       flt;
    int         c;
    void'($urandom(32'h515E1AED));
    repeat (10) @(negedge sys_clk);
    sys_rst <= 1'b0;
    foreach (RST_TBL[k]) rx(RST_TBL[k][15:8], RST_TBL[k][7:0]);
    for (int m = 0; m < 3; m++) begin
      ext = (m != 0);
      cmp = (m == 2);
      w = $urandom;
      host.wr(trr_pkg::ADDR_CONFIG5, {w[7:2], cmp, w[0]});
      range_ext_pin <= ext;
      rx(trr_pkg::ADDR_CONFIG5, {6'h00, cmp, 1'b0});
      for (int i = 0; i < 12; i++) begin
        c = i % 3;
        lo = $urandom;
        hi = $urandom;
        offs[c] = $urandom;
        raw = $urandom;
        flt = ($urandom % 8) == 0;
        // Fixed corners, so that each guarded case is reached at least once.
        case ({m[1:0], i[3:0]})
          6'h00: {offs[c], raw, flt} = {8'h02, 10'h100, 1'b0};
          6'h03: flt = 1'b1;
          6'h05: {lo, offs[c], raw, flt} = {8'h10, 8'h00, 10'h140, 1'b0};
          6'h11: flt = 1'b1;
          6'h12: {offs[c], flt} = {8'h00, 1'b0};
          6'h20: lo = 8'h80;
          6'h21: {offs[c], raw, flt} = {8'hF0, 10'h000, 1'b0};
          default: ;
        endcase
        host.wr(trr_pkg::ADDR_LOW[c], lo);
        host.wr(trr_pkg::ADDR_HIGH[c], hi);
        host.wr(trr_pkg::ADDR_OFFSET[c], offs[c]);
        host.wr(trr_pkg::ADDR_VALUE[c], lo);
        host.idle();
        // Only writes made in the compatible mode are floored.
        if (cmp && $signed(lo) < -63) lo = trr_pkg::COMPAT_FLOOR;
        if (cmp && $signed(hi) < -63) hi = trr_pkg::COMPAT_FLOOR;
        measure(c, raw, flt);
        val[c] = enc(raw, offs[c], flt);
        stat[c] = (sv(val[c]) > sv({hi, 2'b00})) || (sv(val[c]) <= sv({lo, 2'b00}));
        chk("limit_status", stat, limit_status);
        chk("temp_alert", |stat, temp_alert);
        rx(trr_pkg::ADDR_LOW[c], lo);
        rx(trr_pkg::ADDR_OFFSET[c], offs[c]);
        host.idle();
        if (i >= 2) read_wide();
      end
    end
    rx(trr_pkg::ADDR_FRACTION, {val[2][1:0], val[1][1:0], val[0][1:0], 2'b00});
    host.idle();
    measure(0, 10'h2A5, 1'b0);
    chk("frozen", 1'b1, frozen);
    for (int k = 0; k < 3; k++) rx(trr_pkg::ADDR_VALUE[k], val[k][9:2]);
    host.idle();
    val[0] = enc(10'h2A5, offs[0], 1'b0);
    repeat (4) @(negedge sys_clk);
    chk("frozen", 1'b0, frozen);
    rx(trr_pkg::ADDR_VALUE[0], val[0][9:2]);
    host.idle();
    repeat (4) @(negedge sys_clk);
    chk("pending reads", 10'h000, 10'(exp_q.size()));
    print_verdict();
  end

endmodule : trr_result_regs_tb

`default_nettype wire
